// file: hdl/drw_consts.svh
// offsets, field positions, reset values and timing counts of the disk command decoder
`ifndef DRW_CONSTS_SVH
`define DRW_CONSTS_SVH
`define DRW_OFF_CTRL 8'h00
`define DRW_OFF_STATUS 8'h04
`define DRW_OFF_INT_STAT 8'h08
`define DRW_OFF_INT_CLR 8'h0c
`define DRW_OFF_INT_EN 8'h10
`define DRW_CTRL_RESET 32'h0000_0001
`define DRW_CTRL_ONLINE 0
`define DRW_EV_SEEK_FIN 0
`define DRW_EV_SEEK_INC 1
`define DRW_EV_SPEED_LOST 2
`define DRW_EV_FIRST_DONE 3
`define DRW_EV_W 4
`define DRW_CMD_WRITE_LO 0
`define DRW_CMD_WRITE_HI 1
`define DRW_CMD_READ 2
`define DRW_CMD_ERASE 4
`define DRW_CMD_RTZ 6
`define DRW_TRACK_SPLIT 256
`define DRW_SPEED_MIN_RPM 2000
`define DRW_SEEK_TMO_MS 400
`define DRW_CLK_MHZ 100
`define DRW_SEEK_TMO_CYC (`DRW_SEEK_TMO_MS * 1000 * `DRW_CLK_MHZ)
`define DRW_RESP_OKAY 2'b00
`define DRW_RESP_SLVERR 2'b10
`endif

// file: hdl/drw_pkg.sv
// types shared by the disk command decoder
package drw_pkg;
    typedef enum logic [1:0] {
        DRW_SPIN_WAIT = 2'b00,
        DRW_FIRST_SEEK = 2'b01,
        DRW_READY = 2'b11,
        DRW_SEEKING = 2'b10
    } drw_state_e;

    typedef struct packed {
        logic unit_select;
        logic head_dir_tag;
        logic command_tag;
        logic seek_tag;
        logic brush_done;
        logic write_data;
        logic [7:0] bus_bits;
    } drw_pins_s;

    typedef struct packed {
        logic read_gate;
        logic write_gate;
        logic erase_gate;
    } drw_rw_s;
endpackage

// file: hdl/drw_top.sv
// disk unit command decoder: seek status, head latch, read/write/erase decode, axi4-lite regs
// Functional notes
// - seek finished is raised when a seek completes, unit then awaits commands
// - seek started then unit deselected: busy line shows the seek in progress
// - head/direction tag loads the head number into the head address register
// - seek finished rises on both a good seek end and a seek error
// - deselected unit keeps its pending status and waits to be selected again
// - seek incomplete clears only on a return-to-zero pulse, sent when present
// - write comes from bit 0 below track 256, from bit 1 above 255
// - valid write disables read, enables write, passes serial write data
// - erase current is enabled while writing with erase requested
// - command bit 2 starts a read with the same selection and status flow
// - spindle speed enable dropping kills read/write and reverses the carriage
// - speed enable is removed once spindle speed falls below 2000 rpm
// - head-load seek starts after brush cycle; commands accepted after it ends
// - seek motion beyond 400 ms without position reports seek incomplete
`timescale 1ns/1ns
`include "drw_consts.svh"
module drw_top #(
    parameter int HEAD_W = 5,
    parameter int TRACK_W = 9,
    parameter int RPM_W = 16,
    parameter int SEEK_TMO_CYC = `DRW_SEEK_TMO_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire drw_pkg::drw_pins_s pins_in,
    input wire logic on_cylinder,
    input wire logic [TRACK_W-1:0] cur_track,
    input wire logic [RPM_W-1:0] spindle_rpm,
    output logic busy,
    output logic seek_finished,
    output logic seek_incomplete,
    output logic [HEAD_W-1:0] head_addr_r,
    output drw_pkg::drw_rw_s rw_gates,
    output logic write_data_out,
    output logic speed_enable,
    output logic carriage_reverse,
    output logic seek_go,
    output logic return_to_zero_pulse,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int PW = $bits(drw_pkg::drw_pins_s);

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr[7:2] == off[7:2]);
    endfunction

    // pin inputs: three flops, a change counts once stages two and three agree
    logic [PW-1:0] sync1_r, sync2_r, sync3_r, pins_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            pins_r <= '0;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            if (sync2_r == sync3_r) begin
                pins_r <= sync3_r;
            end
        end
    end

    drw_pkg::drw_pins_s pins, pins_d_r;
    assign pins = drw_pkg::drw_pins_s'(pins_r);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pins_d_r <= '0;
        end else begin
            pins_d_r <= pins;
        end
    end

    // tag strobes count only for the selected unit
    wire selected = pins.unit_select;
    wire head_tag_rise = pins.head_dir_tag & ~pins_d_r.head_dir_tag & selected;
    wire cmd_tag_rise = pins.command_tag & ~pins_d_r.command_tag & selected;
    wire seek_tag_rise = pins.seek_tag & ~pins_d_r.seek_tag & selected;

    // spindle speed detection, single threshold both ways
    logic speed_r;
    wire speed_ok = spindle_rpm >= RPM_W'(`DRW_SPEED_MIN_RPM);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            speed_r <= 1'b0;
        end else begin
            speed_r <= speed_ok;
        end
    end
    assign speed_enable = speed_r;
    wire speed_fall = ~speed_ok & speed_r;

    // registers
    logic [31:0] ctrl_r;
    logic [`DRW_EV_W-1:0] int_stat_r, int_en_r;
    wire online = ctrl_r[`DRW_CTRL_ONLINE];

    // seek sequencer
    drw_pkg::drw_state_e state_r, state_nxt;
    logic [31:0] tmo_r;
    logic fin_r, inc_r, rev_r, go_r, rtz_r;
    wire cmd_ok = (state_r == drw_pkg::DRW_READY) && ~inc_r;
    wire rtz_req = cmd_tag_rise && (state_r == drw_pkg::DRW_READY)
        && pins.bus_bits[`DRW_CMD_RTZ];
    wire seek_req = seek_tag_rise && cmd_ok;
    wire seek_active = (state_r == drw_pkg::DRW_SEEKING) || (state_r == drw_pkg::DRW_FIRST_SEEK);
    wire tmo_hit = seek_active && (tmo_r >= 32'(SEEK_TMO_CYC - 1));
    wire seek_end = seek_active && ~go_r && (on_cylinder || tmo_hit);
    wire first_start = (state_r == drw_pkg::DRW_SPIN_WAIT) && speed_r && online
        && pins.brush_done;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            drw_pkg::DRW_SPIN_WAIT: begin
                if (first_start) begin
                    state_nxt = drw_pkg::DRW_FIRST_SEEK;
                end
            end
            drw_pkg::DRW_FIRST_SEEK: begin
                if (seek_end) begin
                    state_nxt = drw_pkg::DRW_READY;
                end
            end
            drw_pkg::DRW_READY: begin
                if (seek_req || rtz_req) begin
                    state_nxt = drw_pkg::DRW_SEEKING;
                end
            end
            drw_pkg::DRW_SEEKING: begin
                if (seek_end) begin
                    state_nxt = drw_pkg::DRW_READY;
                end
            end
        endcase
        if (speed_fall || ~online) begin
            state_nxt = drw_pkg::DRW_SPIN_WAIT;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= drw_pkg::DRW_SPIN_WAIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // timeout counter runs from the first cycle of motion
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tmo_r <= '0;
        end else if (seek_active && ~seek_end) begin
            tmo_r <= tmo_r + 32'h1;
        end else begin
            tmo_r <= '0;
        end
    end

    // seek_go and return-to-zero are one-cycle pulses to the positioner
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            go_r <= 1'b0;
            rtz_r <= 1'b0;
        end else begin
            go_r <= first_start || seek_req || rtz_req;
            rtz_r <= rtz_req;
        end
    end
    assign seek_go = go_r;
    assign return_to_zero_pulse = rtz_r;

    // status flags persist across deselection until reselected and acted upon
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fin_r <= 1'b0;
            inc_r <= 1'b0;
        end else begin
            if (seek_end) begin
                fin_r <= 1'b1;
            end else if (go_r || state_r == drw_pkg::DRW_SPIN_WAIT) begin
                fin_r <= 1'b0;
            end
            if (seek_end && ~on_cylinder) begin
                inc_r <= 1'b1;
            end else if (rtz_req) begin
                inc_r <= 1'b0;
            end
        end
    end
    // seek finished and seek incomplete show only on the selected unit; busy shows only while deselected
    assign seek_finished = fin_r & selected;
    assign seek_incomplete = inc_r & selected;
    assign busy = seek_active & ~selected;

    // carriage reverses from speed loss until the next head-load seek starts
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rev_r <= 1'b0;
        end else if (speed_fall) begin
            rev_r <= 1'b1;
        end else if (first_start) begin
            rev_r <= 1'b0;
        end
    end
    assign carriage_reverse = rev_r;

    // head address latch
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            head_addr_r <= '0;
        end else if (head_tag_rise) begin
            head_addr_r <= pins.bus_bits[HEAD_W-1:0];
        end
    end

    // command decode: write bit depends on which half of the disk the carriage is on
    wire upper_half = cur_track >= TRACK_W'(`DRW_TRACK_SPLIT);
    wire wr_bit = upper_half ? pins.bus_bits[`DRW_CMD_WRITE_HI]
        : pins.bus_bits[`DRW_CMD_WRITE_LO];
    wire cmd_take = cmd_tag_rise && cmd_ok && ~pins.bus_bits[`DRW_CMD_RTZ];
    drw_pkg::drw_rw_s rw_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rw_r <= '0;
        end else if (~speed_r || state_r != drw_pkg::DRW_READY) begin
            rw_r <= '0;
        end else if (cmd_take) begin
            rw_r.write_gate <= wr_bit;
            rw_r.read_gate <= pins.bus_bits[`DRW_CMD_READ] & ~wr_bit;
            rw_r.erase_gate <= wr_bit & pins.bus_bits[`DRW_CMD_ERASE];
        end
    end
    assign rw_gates = rw_r;

    // write data is only passed while the write path is open
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            write_data_out <= 1'b0;
        end else begin
            write_data_out <= pins.write_data & rw_r.write_gate;
        end
    end

    // axi4-lite slave: write address and data taken together, one answer the next cycle
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    wire wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    wire rd_take = s_axi_arvalid & ~rvalid_r;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    wire w_ctrl = wr_take & reg_hit(s_axi_awaddr, `DRW_OFF_CTRL);
    wire w_clr = wr_take & reg_hit(s_axi_awaddr, `DRW_OFF_INT_CLR) & s_axi_wstrb[0];
    wire w_en = wr_take & reg_hit(s_axi_awaddr, `DRW_OFF_INT_EN) & s_axi_wstrb[0];
    wire w_hit = reg_hit(s_axi_awaddr, `DRW_OFF_CTRL) | reg_hit(s_axi_awaddr, `DRW_OFF_INT_CLR)
        | reg_hit(s_axi_awaddr, `DRW_OFF_INT_EN);

    // head number sits at [14:10], bit 9 spare; upper bits read as zero
    wire [31:0] status_word = {22'(head_addr_r), 1'h0, rw_r, busy,
        inc_r, fin_r, speed_r, state_r};
    wire r_ctrl = reg_hit(s_axi_araddr, `DRW_OFF_CTRL);
    wire r_stat = reg_hit(s_axi_araddr, `DRW_OFF_STATUS);
    wire r_ist = reg_hit(s_axi_araddr, `DRW_OFF_INT_STAT);
    wire r_ien = reg_hit(s_axi_araddr, `DRW_OFF_INT_EN);
    wire r_hit = r_ctrl | r_stat | r_ist | r_ien;
    wire [31:0] rd_word = r_ctrl ? ctrl_r : r_stat ? status_word
        : r_ist ? 32'(int_stat_r) : r_ien ? 32'(int_en_r) : 32'h0;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `DRW_CTRL_RESET;
            bvalid_r <= 1'b0;
            bresp_r <= `DRW_RESP_OKAY;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (w_ctrl && s_axi_wstrb[i]) begin
                    ctrl_r[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
                end
            end
            if (wr_take) begin
                bvalid_r <= 1'b1;
                bresp_r <= w_hit ? `DRW_RESP_OKAY : `DRW_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_r <= 1'b0;
            rresp_r <= `DRW_RESP_OKAY;
            rdata_r <= 32'h0;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= r_hit ? `DRW_RESP_OKAY : `DRW_RESP_SLVERR;
            rdata_r <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // interrupt status: a new event in the clearing cycle wins over the clear
    logic [`DRW_EV_W-1:0] ev;
    assign ev[`DRW_EV_SEEK_FIN] = seek_end;
    assign ev[`DRW_EV_SEEK_INC] = seek_end & ~on_cylinder;
    assign ev[`DRW_EV_SPEED_LOST] = speed_fall;
    assign ev[`DRW_EV_FIRST_DONE] = seek_end & (state_r == drw_pkg::DRW_FIRST_SEEK);
    wire [`DRW_EV_W-1:0] clr_mask = w_clr ? s_axi_wdata[`DRW_EV_W-1:0] : '0;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            int_stat_r <= '0;
            int_en_r <= '0;
        end else begin
            int_stat_r <= (int_stat_r & ~clr_mask) | ev;
            if (w_en) begin
                int_en_r <= s_axi_wdata[`DRW_EV_W-1:0];
            end
        end
    end
    assign irq = |(int_stat_r & int_en_r);
endmodule

// file: dv/drw_sva.sv
// port-level assertions for the disk command decoder
`timescale 1ns/1ns
module drw_sva #(
    parameter int HEAD_W = 5,
    parameter int RPM_W = 16
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire drw_pkg::drw_pins_s pins_in,
    input wire logic [RPM_W-1:0] spindle_rpm,
    input wire logic busy,
    input wire logic seek_finished,
    input wire logic seek_incomplete,
    input wire logic [HEAD_W-1:0] head_addr_r,
    input wire drw_pkg::drw_rw_s rw_gates,
    input wire logic speed_enable,
    input wire logic carriage_reverse,
    input wire logic seek_go,
    input wire logic return_to_zero_pulse
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    AST_BUSY_QUIET: assert property (busy |-> !seek_finished && !seek_incomplete)
        else $error("status shown while busy");
    AST_FIN_CLEARED: assert property (seek_go |=> !seek_finished)
        else $error("seek finished kept over a new seek");
    AST_INC_WITH_FIN: assert property ($rose(seek_incomplete) |-> seek_finished)
        else $error("incomplete without finished");
    AST_HEAD_FROM_TAG: assert property (!$stable(head_addr_r) |-> $past(pins_in.head_dir_tag, 3))
        else $error("head number moved without tag");
    AST_WR_NOT_RD: assert property (rw_gates.write_gate |-> !rw_gates.read_gate)
        else $error("read and write both on");
    AST_ERASE_NEEDS_WR: assert property (rw_gates.erase_gate |-> rw_gates.write_gate)
        else $error("erase without write");
    AST_SPEED_LEVEL: assert property ($past(reset_n) |-> speed_enable == ($past(spindle_rpm) >= 2000))
        else $error("speed enable wrong");
    AST_SPEED_KILL: assert property ($fell(speed_enable) |-> ##[1:2] (rw_gates == 3'h0 && carriage_reverse))
        else $error("speed loss left gates on");
    AST_RTZ_PAIR: assert property (return_to_zero_pulse |-> seek_go ##1 !seek_incomplete)
        else $error("return to zero did not clear");
    AST_SEL_FOR_CMD: assert property ($rose(rw_gates.write_gate) |-> $past(pins_in.unit_select, 4))
        else $error("write taken while not selected");
    cover property (return_to_zero_pulse);
    cover property ($rose(busy));
    cover property ($rose(rw_gates.erase_gate));
endmodule
bind drw_top drw_sva #(.HEAD_W(HEAD_W), .RPM_W(RPM_W)) u_sva (.mclk(mclk), .reset_n(reset_n),
    .pins_in(pins_in), .spindle_rpm(spindle_rpm), .busy(busy), .seek_finished(seek_finished),
    .seek_incomplete(seek_incomplete), .head_addr_r(head_addr_r), .rw_gates(rw_gates),
    .speed_enable(speed_enable), .carriage_reverse(carriage_reverse), .seek_go(seek_go),
    .return_to_zero_pulse(return_to_zero_pulse));

// file: dv/drw_ctl_model.sv
// controller-side model driving the unit's tag and command pins
`timescale 1ns/1ns
module drw_ctl_model (
    input wire logic mclk,
    input wire logic seek_finished,
    input wire logic seek_incomplete,
    output drw_pkg::drw_pins_s pins
);
    initial pins = '0;
    task automatic lines(input logic sel, input logic brush, input logic wd);
        @(posedge mclk);
        pins.unit_select <= sel;
        pins.brush_done <= brush;
        pins.write_data <= wd;
    endtask
    // which: 0 head, 1 command, 2 seek; tag held long so the three-flop sync sees it
    task automatic strobe(input int which, input logic [7:0] b);
        @(posedge mclk);
        pins.bus_bits <= b;
        repeat (2) @(posedge mclk);
        pins.head_dir_tag <= (which == 0);
        pins.command_tag <= (which == 1);
        pins.seek_tag <= (which == 2);
        repeat (6) @(posedge mclk);
        pins.head_dir_tag <= 1'h0;
        pins.command_tag <= 1'h0;
        pins.seek_tag <= 1'h0;
        repeat (4) @(posedge mclk);
        // released bus shows the inverse, never a stale copy
        pins.bus_bits <= ~b;
    endtask
    task automatic write_cmd(input logic erase, input logic hi);
        if (seek_incomplete === 1'h1)
            strobe(1, 8'h40);
        else
            strobe(1, {3'h0, erase, 2'h0, hi, !hi});
    endtask
endmodule

// file: dv/disk_read_write_command_decode_bench.sv
// self-checking bench for the disk command decoder
`timescale 1ns/1ns
module disk_read_write_command_decode_bench;
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    drw_pkg::drw_pins_s pins;
    drw_pkg::drw_rw_s rw_gates;
    logic on_cylinder, busy, seek_finished, seek_incomplete, write_data_out, speed_enable;
    logic carriage_reverse, seek_go, return_to_zero_pulse, irq;
    logic [8:0] cur_track = 9'h0ff;
    logic [15:0] spindle_rpm = 16'h0;
    logic [4:0] head_addr_r;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, no_cyl = 1'h0;
    logic [1:0] bresp, rresp, r;
    logic [8:0] trk [5] = '{9'h0ff, 9'h100, 9'h100, 9'h100, 9'h0ff};
    logic [7:0] cmd [5] = '{8'h11, 8'h01, 8'h12, 8'h04, 8'h06};
    logic [2:0] gat [5] = '{3'h3, 3'h0, 3'h3, 3'h4, 3'h4};
    int cnt = 0, cyc = 0, rtz_cnt = 0, error_cnt = 0, checks = 0;
    always #5 mclk = ~mclk;
    // servo stand-in: settles 30 cycles after each seek start unless told to stall
    assign on_cylinder = !seek_go && cnt == 0 && !no_cyl;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rtz_cnt <= rtz_cnt + return_to_zero_pulse;
        cnt <= seek_go ? 30 : (cnt > 0 ? cnt - 1 : 0);
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            wrap_up();
        end
    end
    drw_top #(.SEEK_TMO_CYC(50)) i_dut (.mclk(mclk), .reset_n(reset_n), .pins_in(pins),
        .on_cylinder(on_cylinder), .cur_track(cur_track), .spindle_rpm(spindle_rpm),
        .busy(busy), .seek_finished(seek_finished), .seek_incomplete(seek_incomplete),
        .head_addr_r(head_addr_r), .rw_gates(rw_gates), .write_data_out(write_data_out),
        .speed_enable(speed_enable), .carriage_reverse(carriage_reverse), .seek_go(seek_go),
        .return_to_zero_pulse(return_to_zero_pulse), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    drw_ctl_model i_ctl (.mclk(mclk), .seek_finished(seek_finished),
        .seek_incomplete(seek_incomplete), .pins(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do @(posedge mclk); while (!(awready && wready));
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        while (!bvalid) @(posedge mclk);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'h0;
        while (!rvalid) @(posedge mclk);
        v = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        tick(6);
        reset_n <= 1'h1;
        rd(8'h00, d, r);
        chk(d, 32'h1);
        rd(8'h20, d, r);
        chk(r, 2'h2);
        wr(8'h04, 32'h0, r);
        chk(r, 2'h2);
        wr(8'h10, 32'hf, r);
        chk(r, 2'h0);
        i_ctl.lines(1'h1, 1'h0, 1'h0);
        spindle_rpm <= 16'h0bb8;
        tick(20);
        rd(8'h04, d, r);
        chk(d, 32'h4);
        i_ctl.lines(1'h1, 1'h1, 1'h0);
        tick(60);
        rd(8'h04, d, r);
        chk(d, 32'hf);
        chk(irq, 1'h1);
        rd(8'h08, d, r);
        chk(d, 32'h9);
        wr(8'h0c, 32'hf, r);
        tick(1);
        chk(irq, 1'h0);
        i_ctl.strobe(0, 8'h15);
        tick(2);
        chk(head_addr_r, 5'h15);
        // track 255/256 edge, write bit swap, erase, read
        for (int i = 0; i < 5; i++) begin
            cur_track <= trk[i];
            i_ctl.strobe(1, cmd[i]);
            tick(2);
            chk(rw_gates, gat[i]);
        end
        i_ctl.write_cmd(1'h0, 1'h0);
        tick(2);
        chk(rw_gates, 3'h2);
        i_ctl.lines(1'h1, 1'h1, 1'h1);
        tick(6);
        chk(write_data_out, 1'h1);
        i_ctl.lines(1'h1, 1'h1, 1'h0);
        tick(6);
        chk(write_data_out, 1'h0);
        i_ctl.lines(1'h0, 1'h1, 1'h0);
        tick(6);
        i_ctl.strobe(1, 8'h04);
        tick(2);
        chk(rw_gates, 3'h2);
        i_ctl.lines(1'h1, 1'h1, 1'h0);
        tick(6);
        i_ctl.strobe(2, 8'h00);
        i_ctl.lines(1'h0, 1'h1, 1'h0);
        tick(6);
        chk(busy, 1'h1);
        chk(seek_finished, 1'h0);
        tick(30);
        chk(busy, 1'h0);
        i_ctl.lines(1'h1, 1'h1, 1'h0);
        tick(6);
        chk(seek_finished, 1'h1);
        no_cyl <= 1'h1;
        i_ctl.strobe(2, 8'h00);
        tick(60);
        chk(seek_incomplete, 1'h1);
        chk(seek_finished, 1'h1);
        i_ctl.strobe(1, 8'h04);
        tick(2);
        chk(rw_gates, 3'h0);
        no_cyl <= 1'h0;
        i_ctl.write_cmd(1'h1, 1'h0);
        tick(40);
        chk(rtz_cnt, 1);
        chk(seek_incomplete, 1'h0);
        chk(seek_finished, 1'h1);
        i_ctl.strobe(1, 8'h04);
        tick(2);
        chk(rw_gates, 3'h4);
        wr(8'h10, 32'h4, r);
        tick(1);
        chk(irq, 1'h0);
        spindle_rpm <= 16'h07cf;
        tick(4);
        chk(speed_enable, 1'h0);
        chk(rw_gates, 3'h0);
        chk(carriage_reverse, 1'h1);
        chk(irq, 1'h1);
        rd(8'h04, d, r);
        chk(d[1:0], 2'h0);
        wrap_up();
    end
endmodule
